/* File: hdl/rtc_supervisor_pkg.sv */
`default_nettype none
package rtc_supervisor_pkg;

  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned OSC_HZ = 32_768;

  // Recovery delay after supply returns, microseconds
  localparam int unsigned RECOVERY_TYP_US = 1_000;
  localparam int unsigned RECOVERY_MAX_US = 2_000;
  localparam int unsigned RECOVERY_CYCLES = (CLK_HZ / 1_000_000) * RECOVERY_TYP_US;

  // Oscillator stop detection period, milliseconds
  localparam int unsigned OSC_STOP_MAX_MS = 100;
  localparam int unsigned OSC_STOP_CYCLES = (CLK_HZ / 1_000) * OSC_STOP_MAX_MS;

  // Bus clock low timeout, milliseconds
  localparam int unsigned BUS_TIMEOUT_MIN_MS = 25;
  localparam int unsigned BUS_TIMEOUT_MAX_MS = 35;
  localparam int unsigned BUS_TIMEOUT_CYCLES = (CLK_HZ / 1_000) * BUS_TIMEOUT_MIN_MS;

  // Oscillator edge watchdog: no edge within this many cycles means halted
  localparam int unsigned OSC_EDGE_GAP_CYCLES = 2 * (CLK_HZ / OSC_HZ);

  // Length of the interface reset pulse
  localparam int unsigned BUS_RESET_CYCLES = 4;

  localparam int unsigned CNT_W = 24;

  // Square-wave divide ratio select, default 1 Hz from the oscillator
  localparam logic [14:0] SQW_DIV_RESET = 15'h3fff;

  typedef enum logic [1:0] {
    PWR_DOWN,
    PWR_RECOVER,
    PWR_READY
  } pwr_state_e;

  typedef struct packed {
    logic vcc_above_pf;
    logic backup_supply;
    logic osc_enable;
  } supply_in_s;

  typedef struct packed {
    logic access_allowed;
    logic osc_running;
    logic osc_stop_flag;
    logic timeout_seen;
  } status_out_s;

endpackage : rtc_supervisor_pkg
`default_nettype wire

/* File: hdl/rtc_power_access_supervisor.sv */
`default_nettype none
module rtc_power_access_supervisor
  import rtc_supervisor_pkg::*;
#(
  parameter int unsigned RECOVERY_CYC = RECOVERY_CYCLES,
  parameter int unsigned OSC_STOP_CYC = OSC_STOP_CYCLES,
  parameter int unsigned TIMEOUT_CYC  = BUS_TIMEOUT_CYCLES,
  parameter int unsigned OSC_GAP_CYC  = OSC_EDGE_GAP_CYCLES
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Supply and oscillator status pins
  input  wire supply_in_s  i_supply,
  input  wire logic        i_osc,
  input  wire logic        i_osc_stop_clear,
  // Serial bus pins
  input  wire logic        i_bus_clock,
  input  wire logic        i_data_in,
  // Data line request from the serial slave core
  input  wire logic        i_core_data_low,
  // Square-wave and interrupt configuration
  input  wire logic        i_irq_mode,
  input  wire logic        i_irq_active,
  input  wire logic        i_sqw_enable,
  // Serial slave core control
  output logic             o_core_reset,
  output logic             o_access_allowed,
  output logic             o_tick_1hz,
  // Open-drain data line
  output logic             o_data_out,
  output logic             o_data_oe,
  // Open-drain square-wave or interrupt line
  output logic             o_square_wave_or_irq_out,
  output logic             o_square_wave_or_irq_oe,
  // Status
  output status_out_s      o_status
);

  typedef struct packed {
    logic [1:0]       vcc_sync;
    logic [1:0]       bak_sync;
    logic [1:0]       oen_sync;
    logic [1:0]       osc_sync;
    logic [1:0]       clr_sync;
    logic [1:0]       scl_sync;
    logic             osc_prev;
    logic [CNT_W-1:0] gap_cnt;
    logic             osc_running;
    logic [CNT_W-1:0] stop_cnt;
    logic             osc_stop_flag;
    pwr_state_e       pwr;
    logic [CNT_W-1:0] rec_cnt;
    logic [CNT_W-1:0] low_cnt;
    logic             timeout_seen;
    logic             timeout_done;
    logic [2:0]       rst_cnt;
    logic             core_reset;
    logic             access;
    logic [14:0]      div_cnt;
    logic             sqw;
    logic             tick;
    logic             data_oe;
    logic             pin_oe;
  } state_s;

  state_s cur;
  state_s nxt;

  logic vcc_ok;
  logic osc_edge;
  logic scl_low;

  function automatic logic cnt_hit(input logic [CNT_W-1:0] cnt, input int unsigned lim);
    cnt_hit = (cnt >= CNT_W'(lim - 1));
  endfunction : cnt_hit

  assign vcc_ok   = cur.vcc_sync[1];
  assign osc_edge = cur.osc_sync[1] & ~cur.osc_prev;
  assign scl_low  = ~cur.scl_sync[1];

  always_comb begin
    nxt = cur;
    nxt.vcc_sync = {cur.vcc_sync[0], i_supply.vcc_above_pf};
    nxt.bak_sync = {cur.bak_sync[0], i_supply.backup_supply};
    nxt.oen_sync = {cur.oen_sync[0], i_supply.osc_enable};
    nxt.osc_sync = {cur.osc_sync[0], i_osc};
    nxt.clr_sync = {cur.clr_sync[0], i_osc_stop_clear};
    nxt.scl_sync = {cur.scl_sync[0], i_bus_clock};
    nxt.osc_prev = cur.osc_sync[1];
    nxt.tick     = 1'b0;

    // Oscillator activity watchdog
    if (osc_edge) begin
      nxt.gap_cnt     = '0;
      nxt.osc_running = cur.oen_sync[1];
    end else if (cnt_hit(cur.gap_cnt, OSC_GAP_CYC)) begin
      nxt.osc_running = 1'b0;
    end else begin
      nxt.gap_cnt = cur.gap_cnt + CNT_W'(1);
    end
    if (!cur.oen_sync[1]) begin
      nxt.osc_running = 1'b0;
    end

    if (cur.osc_running) begin
      nxt.stop_cnt = '0;
    end else if (!cnt_hit(cur.stop_cnt, OSC_STOP_CYC)) begin
      nxt.stop_cnt = cur.stop_cnt + CNT_W'(1);
    end
    if (cur.clr_sync[1]) begin
      nxt.osc_stop_flag = 1'b0;
    end
    if (!cur.osc_running && cnt_hit(cur.stop_cnt, OSC_STOP_CYC)) begin
      nxt.osc_stop_flag = 1'b1;
    end

    unique case (cur.pwr)
      PWR_DOWN: begin
        nxt.rec_cnt = '0;
        if (vcc_ok) begin
          nxt.pwr = cur.osc_running ? PWR_RECOVER : PWR_READY;
        end
      end
      PWR_RECOVER: begin
        nxt.rec_cnt = cur.rec_cnt + CNT_W'(1);
        if (!vcc_ok) begin
          nxt.pwr = PWR_DOWN;
        end else if (!cur.osc_running || cnt_hit(cur.rec_cnt, RECOVERY_CYC)) begin
          nxt.pwr = PWR_READY;
        end
      end
      PWR_READY: begin
        if (!vcc_ok) begin
          nxt.pwr = PWR_DOWN;
        end
      end
    endcase
    nxt.access = (nxt.pwr == PWR_READY);

    if (!scl_low || !cur.osc_running) begin
      nxt.low_cnt      = '0;
      nxt.timeout_done = 1'b0;
    end else if (!cnt_hit(cur.low_cnt, TIMEOUT_CYC)) begin
      nxt.low_cnt = cur.low_cnt + CNT_W'(1);
    end
    if (cur.osc_running && scl_low && cnt_hit(cur.low_cnt, TIMEOUT_CYC)
        && !cur.timeout_done) begin
      nxt.timeout_seen = 1'b1;
      nxt.timeout_done = 1'b1;
      nxt.rst_cnt      = 3'(BUS_RESET_CYCLES);
    end else if (cur.rst_cnt != 3'h0) begin
      nxt.rst_cnt = cur.rst_cnt - 3'h1;
    end
    if (!scl_low) begin
      nxt.timeout_seen = 1'b0;
    end
    nxt.core_reset = (nxt.rst_cnt != 3'h0) | ~nxt.access;

    // Divider keeps running on either supply
    if (osc_edge) begin
      if (cur.div_cnt == 15'h0) begin
        nxt.div_cnt = SQW_DIV_RESET;
        nxt.sqw     = ~cur.sqw;
        nxt.tick    = cur.sqw;
      end else begin
        nxt.div_cnt = cur.div_cnt - 15'h1;
      end
    end

    nxt.data_oe = i_core_data_low & ~nxt.core_reset & ~cur.timeout_seen;
    nxt.pin_oe = i_irq_mode ? i_irq_active : (i_sqw_enable & cur.osc_running & ~cur.sqw);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cur          <= '0;
      cur.pwr      <= PWR_DOWN;
      cur.div_cnt  <= SQW_DIV_RESET;
      cur.scl_sync <= 2'h3;
      cur.core_reset <= 1'b1;
    end else begin
      cur <= nxt;
    end
  end

  assign o_core_reset             = cur.core_reset;
  assign o_access_allowed         = cur.access;
  assign o_tick_1hz               = cur.tick;
  assign o_data_out               = 1'b0;
  assign o_data_oe                = cur.data_oe;
  assign o_square_wave_or_irq_out = 1'b0;
  assign o_square_wave_or_irq_oe  = cur.pin_oe;
  assign o_status = '{access_allowed: cur.access, osc_running: cur.osc_running,
                      osc_stop_flag: cur.osc_stop_flag, timeout_seen: cur.timeout_seen};

  logic unused_data_in;
  assign unused_data_in = i_data_in;

endmodule : rtc_power_access_supervisor
`default_nettype wire

/* File: verification/rtc_supervisor_monitor.sv */
`default_nettype none
module rtc_supervisor_monitor
  import rtc_supervisor_pkg::*;
#(
  parameter int unsigned OSC_STOP_CYC = 200,
  parameter int unsigned TIMEOUT_CYC  = 50
) (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire supply_in_s  i_supply,
  input wire logic        i_bus_clock,
  input wire logic        i_irq_mode,
  input wire logic        i_irq_active,
  input wire logic        o_access_allowed,
  input wire logic        o_data_out,
  input wire logic        o_data_oe,
  input wire logic        o_square_wave_or_irq_out,
  input wire logic        o_square_wave_or_irq_oe,
  input wire status_out_s o_status
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic [CNT_W-1:0] stop_cnt;
  logic [CNT_W-1:0] low_cnt;
  // Cycles since the oscillator halted; bus clock low while it runs
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stop_cnt <= '0;
      low_cnt  <= '0;
    end else begin
      stop_cnt <= o_status.osc_running ? CNT_W'(1) : (stop_cnt != 0 ? stop_cnt + 1'b1 : '0);
      low_cnt  <= (i_bus_clock || !o_status.osc_running) ? '0 : low_cnt + 1'b1;
    end
  end
  AST_ACC_OFF: assert property (!i_supply.vcc_above_pf [*5] |-> !o_access_allowed)
    else $error("access while supply low");
  AST_RECOV: assert property (!i_supply.vcc_above_pf [*5] ##1
    (i_supply.vcc_above_pf && o_status.osc_running) |-> !o_access_allowed [*8])
    else $error("access before recovery");
  AST_NO_RECOV: assert property ((!i_supply.osc_enable && !i_supply.vcc_above_pf) [*5]
    ##1 (i_supply.vcc_above_pf && !i_supply.osc_enable) [*8] |-> o_access_allowed)
    else $error("delay with oscillator off");
  AST_STOP_EARLY: assert property ($rose(o_status.osc_stop_flag) |->
    stop_cnt >= OSC_STOP_CYC - 2) else $error("stop flag early");
  AST_STOP_BOUND: assert property (stop_cnt == CNT_W'(OSC_STOP_CYC + 4) |->
    o_status.osc_stop_flag) else $error("stop flag late");
  AST_TO_EARLY: assert property ($rose(o_status.timeout_seen) |->
    low_cnt >= TIMEOUT_CYC) else $error("timeout early");
  AST_TO_BOUND: assert property (low_cnt == CNT_W'(TIMEOUT_CYC + 6) |->
    o_status.timeout_seen) else $error("timeout missed");
  AST_TO_REL: assert property (o_status.timeout_seen && !i_bus_clock |-> !o_data_oe)
    else $error("data line held after timeout");
  AST_OD: assert property (!o_data_out && !o_square_wave_or_irq_out)
    else $error("pin driven high");
  AST_IRQ: assert property ((i_irq_mode && i_irq_active) [*4] |-> o_square_wave_or_irq_oe)
    else $error("interrupt not pulled low");
endmodule : rtc_supervisor_monitor
`default_nettype wire

/* File: verification/rtc_host_model.sv */
`default_nettype none
module rtc_host_model (
  input  wire logic i_clk,
  input  wire logic i_hold_low,
  input  wire logic i_dev_pull,
  output logic      o_scl,
  output logic      o_sda
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ph = '0;
  initial o_scl = 1'b1;
  // low phases short unless a stall is commanded
  always @(negedge i_clk) begin
    ph    <= ph + 2'd1;
    o_scl <= i_hold_low ? 1'b0 : ph[1];
  end
  // pull-up wins unless the device pulls
  assign o_sda = !i_dev_pull;
endmodule : rtc_host_model
`default_nettype wire

/* File: verification/rtc_power_access_supervisor_tb.sv */
`default_nettype none
module rtc_power_access_supervisor_tb;
  import rtc_supervisor_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, osc = 0, osc_run = 1, clr = 0, hold = 0, core_low = 1;
  logic irq_mode = 0, irq_act = 0, sqw_en = 1, scl, sda, core_rst, acc, d_out, d_oe, q_out, q_oe;
  supply_in_s  sup = 3'b111;
  status_out_s st;
  int error_cnt = 0, n_checks = 0;
  always #25 clk = ~clk;
  always #100 if (osc_run) osc = ~osc;
  rtc_power_access_supervisor #(.RECOVERY_CYC(20), .OSC_STOP_CYC(200), .TIMEOUT_CYC(50),
    .OSC_GAP_CYC(10)) u_dut (.i_clk(clk), .i_rst(rst), .i_supply(sup), .i_osc(osc),
    .i_osc_stop_clear(clr), .i_bus_clock(scl), .i_data_in(sda), .i_core_data_low(core_low),
    .i_irq_mode(irq_mode), .i_irq_active(irq_act), .i_sqw_enable(sqw_en),
    .o_core_reset(core_rst), .o_access_allowed(acc), .o_tick_1hz(), .o_data_out(d_out),
    .o_data_oe(d_oe), .o_square_wave_or_irq_out(q_out), .o_square_wave_or_irq_oe(q_oe),
    .o_status(st));
  rtc_host_model u_host (.i_clk(clk), .i_hold_low(hold), .i_dev_pull(d_oe), .o_scl(scl),
    .o_sda(sda));
  task chk(input logic got, input logic exp, input string m);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task t_recover;
    sup.vcc_above_pf = 0;
    cyc(10);
    chk(acc, 0, "access below threshold");
    chk(core_rst, 1, "core not held");
    sup.vcc_above_pf = 1;
    cyc(15);
    chk(acc, 0, "access before recovery");
    cyc(25);
    chk(acc, 1, "no access after recovery");
    $display("t_recover done");
  endtask : t_recover
  task t_norecov;
    sup = 3'b010;
    cyc(10);
    sup.vcc_above_pf = 1;
    cyc(8);
    chk(acc, 1, "delay with oscillator off");
    sup.osc_enable = 1;
    cyc(10);
    $display("t_norecov done");
  endtask : t_norecov
  task t_timeout;
    logic got;
    got = 1'b0;
    hold = 1;
    cyc(45);
    chk(st.timeout_seen, 0, "early timeout");
    // Interface reset pulse must show within the window
    repeat (15) begin
      @(negedge clk);
      if (core_rst === 1'b1) got = 1'b1;
    end
    chk(got, 1, "no interface reset");
    chk(st.timeout_seen, 1, "timeout missed");
    chk(d_oe, 0, "data line held");
    chk(sda, 1, "data line not released");
    hold = 0;
    cyc(10);
    $display("t_timeout done");
  endtask : t_timeout
  task t_stop;
    osc_run = 0;
    cyc(150);
    chk(st.osc_stop_flag, 0, "stop flag before period");
    hold = 1;
    cyc(80);
    chk(st.osc_stop_flag, 1, "stop flag missing");
    chk(st.timeout_seen, 0, "timeout with oscillator stopped");
    hold = 0;
    osc_run = 1;
    cyc(20);
    clr = 1;
    cyc(5);
    clr = 0;
    chk(st.osc_stop_flag, 0, "stop flag not cleared");
    $display("t_stop done");
  endtask : t_stop
  task t_irq;
    irq_mode = 1;
    irq_act = 1;
    cyc(5);
    chk(q_oe, 1, "interrupt not pulled");
    chk(q_out, 0, "pin driven high");
    irq_act = 0;
    cyc(5);
    chk(q_oe, 0, "interrupt stuck");
    irq_mode = 0;
    sqw_en = 0;
    cyc(5);
    chk(q_oe, 0, "square wave pulls while disabled");
    sqw_en = 1;
    cyc(5);
    chk(q_oe, 1, "square wave low phase not pulled");
    $display("t_irq done");
  endtask : t_irq
  task report_and_stop;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  initial begin
    cyc(20);
    rst = 0;
    cyc(40);
    t_recover();
    t_norecov();
    t_timeout();
    t_stop();
    t_irq();
    report_and_stop();
  end
  initial begin
    #(50 * 5000);
    error_cnt++;
    report_and_stop();
  end
endmodule : rtc_power_access_supervisor_tb
bind rtc_power_access_supervisor rtc_supervisor_monitor #(.OSC_STOP_CYC(OSC_STOP_CYC),
  .TIMEOUT_CYC(TIMEOUT_CYC)) u_mon (.i_clk, .i_rst, .i_supply, .i_bus_clock, .i_irq_mode,
  .i_irq_active, .o_access_allowed, .o_data_out, .o_data_oe, .o_square_wave_or_irq_out,
  .o_square_wave_or_irq_oe, .o_status);
`default_nettype wire
